// [inc/psdr_pkg.sv]
`default_nettype none
package psdr_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_RESTART_DEADBAND = 8'h00;
  localparam logic [7:0] OFS_PULSE_STEERING   = 8'h04;
  localparam logic [7:0] OFS_MODE_CTRL        = 8'h08;
  localparam logic [7:0] OFS_SHUTDOWN_CTRL    = 8'h0c;
  localparam logic [7:0] OFS_PERIOD_LIMIT     = 8'h10;
  localparam logic [7:0] OFS_DUTY             = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h1c;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_RESTART_DEADBAND = 8'h00;
  localparam logic [6:0] RST_PULSE_STEERING   = 7'h01;
  localparam logic [6:0] RST_MODE_CTRL        = 7'h00;
  localparam logic [7:0] RST_SHUTDOWN_CTRL    = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT     = 8'hff;
  localparam logic [7:0] RST_DUTY             = 8'h80;

  // ****************************************
  // Field codes and bit positions
  // ****************************************
  localparam logic [1:0] PWM_MODE_HI      = 2'h3;
  localparam logic [1:0] CFG_SINGLE       = 2'h0;
  localparam logic [1:0] CFG_HALF_BRIDGE  = 2'h2;
  localparam logic [1:0] PAIR_NONE        = 2'h0;
  localparam logic [1:0] PAIR_AB          = 2'h1;
  localparam logic [1:0] PAIR_AC          = 2'h2;
  localparam logic [1:0] PAIR_AD          = 2'h3;
  localparam int         IRQ_BIT_SHUTDOWN = 0;
  localparam int         IRQ_BIT_PERIOD   = 1;
  localparam logic [6:0] DB_COUNT_ZERO    = 7'h00;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic       restart_auto_enable;
    logic [6:0] dead_band_count;
  } psdr_rdb_type;

  // Bit 5 is not stored; it is inserted as zero on read
  typedef struct packed {
    logic [1:0] compl_pair_select;
    logic       steer_sync_select;
    logic       steer_enable_d;
    logic       steer_enable_c;
    logic       steer_enable_b;
    logic       steer_enable_a;
  } psdr_steer_type;

  typedef struct packed {
    logic       timer_run;
    logic [1:0] output_config_bits;
    logic [3:0] capcomp_mode_bits;
  } psdr_mode_type;

  typedef struct packed {
    logic       shutdown_event_flag;
    logic [2:0] shutdown_source_sel;
    logic [1:0] shutdown_state_pair_ac;
    logic [1:0] shutdown_state_pair_bd;
  } psdr_sdc_type;

  typedef struct packed {
    logic [6:0] cnt;
    logic       out;
  } psdr_db_state_type;

  typedef struct packed {
    psdr_rdb_type   rdb;
    psdr_steer_type steer;
    psdr_steer_type steer_eff;
    psdr_mode_type  mode;
    psdr_sdc_type   sdc;
    logic [7:0]     period_limit;
    logic [7:0]     duty;
    logic [7:0]     period_timer;
    logic           shut_hold;
    logic           flag_prev;
    logic [1:0]     irq_stat;
    logic [1:0]     irq_mask;
    logic           flt_s1;
    logic           flt_s2;
    logic [1:0]     cmp_s1;
    logic [1:0]     cmp_s2;
    logic [3:0]     pin_out;
    logic [3:0]     pin_oe;
    logic [3:0]     pin_own;
    logic           ack;
    logic [31:0]    rdata;
  } psdr_state_type;

endpackage : psdr_pkg
`default_nettype wire

// [rtl/psdr_deadband.sv]
`timescale 1ns/1ps
`default_nettype none
module psdr_deadband (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       freeze,
  input  wire logic       active_in,
  input  wire logic [6:0] delay_count,
  output logic            active_out
);

  psdr_pkg::psdr_db_state_type q;
  psdr_pkg::psdr_db_state_type d;

  // ****************************************
  // Rising edges wait out the delay, falling edges pass at once
  // ****************************************
  always_comb begin
    d = q;
    if (!freeze) begin
      if (!active_in) begin
        d.out = 1'b0;
        d.cnt = psdr_pkg::DB_COUNT_ZERO;
      end else if (!q.out) begin
        // A count lowered mid-wait ends the wait instead of wrapping past 127
        if (q.cnt >= delay_count) begin
          d.out = 1'b1;
        end else begin
          d.cnt = q.cnt + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active_out = q.out;

endmodule : psdr_deadband
`default_nettype wire

// [rtl/psdr_top.sv]
// Summary of operation
// - With auto restart on, event flag clears itself once shutdown cause is gone.
// - Each inactive-to-active edge is delayed by the dead-band count in cycles.
// - Steering works only with mode bits 3:2 at 11 and output config 00.
// - A set steer enable routes the polarised waveform to its pin, else port.
// - In steering mode the low two mode bits set pin polarity.
// - Shutdown forces only pins that carry PWM output.
// - Pair field 00 uses steer enables; 01 A/B, 10 A/C, 11 A/D.
// - Sync bit 0: steering changes right after the register write.
// - Sync bit 1: steering changes at the next period start.
// - Bit 5 of the steering register always reads zero.
// - In sleep the timer and PWM logic freeze, pins hold; bus register writes still land.
// - In primary idle the module keeps running unchanged.
// - Dead band is inserted only on non-active to active transitions.
// - After shutdown ends, outputs stay shut until the next period starts.
// - Pair A/C and B/D shutdown field: 00 low, 01 high, 1x tri-state.
// - Shutdown is level sensitive and persists while the condition stands.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module psdr_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SLEEP,
  input  wire logic        FAULT_N,
  input  wire logic        CMP1_OUT,
  input  wire logic        CMP2_OUT,
  output logic      [3:0]  PWM_OUT,
  output logic      [3:0]  PWM_OE,
  output logic      [3:0]  PWM_OWN,
  output logic             PERIOD_START,
  output logic             IRQ
);

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {drive enable, level} for a pair in shutdown
  function automatic logic [1:0] psdr_pss_drive(input logic [1:0] pss);
    case (pss)
      2'h0:    psdr_pss_drive = 2'h2;
      2'h1:    psdr_pss_drive = 2'h3;
      default: psdr_pss_drive = 2'h0;
    endcase
  endfunction : psdr_pss_drive

  function automatic logic psdr_w1(input logic sel, input logic we, input logic hit);
    psdr_w1 = sel && we && hit;
  endfunction : psdr_w1

  psdr_pkg::psdr_state_type q;
  psdr_pkg::psdr_state_type d;

  logic       req;
  logic       period_start;
  logic       sd_cond;
  logic       fault_act;
  logic       steer_mode;
  logic       half_bridge;
  logic       pwm_raw;
  logic       db_main;
  logic       db_comp;
  logic       forced;
  logic [3:0] act;
  logic [3:0] own;
  logic [3:0] pol_low;
  logic [1:0] drv_ac;
  logic [1:0] drv_bd;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // ****************************************
  // Dead-band units for the main and complementary waveforms
  // ****************************************
  psdr_deadband u_db_main (
    .clk         (REF_CLK),
    .rst_n       (RST_N),
    .freeze      (SLEEP),
    .active_in   (pwm_raw),
    .delay_count (q.rdb.dead_band_count),
    .active_out  (db_main)
  );

  psdr_deadband u_db_comp (
    .clk         (REF_CLK),
    .rst_n       (RST_N),
    .freeze      (SLEEP),
    .active_in   (~pwm_raw),
    .delay_count (q.rdb.dead_band_count),
    .active_out  (db_comp)
  );

  // ****************************************
  // Shared combinational terms
  // ****************************************
  always_comb begin
    req          = WB_CYC_I && WB_STB_I && !q.ack;
    wbyte        = WB_DAT_I[7:0];
    // Idle needs no gating here: only sleep freezes the module
    period_start = q.mode.timer_run && !SLEEP
                   && (q.period_timer == q.period_limit);
    fault_act    = !q.flt_s2;
    sd_cond      = (q.sdc.shutdown_source_sel[0] && q.cmp_s2[0])
                || (q.sdc.shutdown_source_sel[1] && q.cmp_s2[1])
                || (q.sdc.shutdown_source_sel[2] && fault_act);
    steer_mode   = (q.mode.capcomp_mode_bits[3:2] == psdr_pkg::PWM_MODE_HI)
                && (q.mode.output_config_bits == psdr_pkg::CFG_SINGLE);
    half_bridge  = (q.mode.capcomp_mode_bits[3:2] == psdr_pkg::PWM_MODE_HI)
                && (q.mode.output_config_bits == psdr_pkg::CFG_HALF_BRIDGE);
    pwm_raw      = q.mode.timer_run && (q.period_timer < q.duty);
    forced       = q.sdc.shutdown_event_flag || q.shut_hold;
    drv_ac       = psdr_pss_drive(q.sdc.shutdown_state_pair_ac);
    drv_bd       = psdr_pss_drive(q.sdc.shutdown_state_pair_bd);
    pol_low      = {q.mode.capcomp_mode_bits[0], q.mode.capcomp_mode_bits[1],
                    q.mode.capcomp_mode_bits[0], q.mode.capcomp_mode_bits[1]};
    act          = 4'h0;
    own          = 4'h0;
    if (steer_mode) begin
      case (q.steer_eff.compl_pair_select)
        psdr_pkg::PAIR_AB: begin
          own = 4'h3;
          act = {2'h0, db_comp, db_main};
        end
        psdr_pkg::PAIR_AC: begin
          own = 4'h5;
          act = {1'b0, db_comp, 1'b0, db_main};
        end
        psdr_pkg::PAIR_AD: begin
          own = 4'h9;
          act = {db_comp, 2'h0, db_main};
        end
        default: begin
          own = {q.steer_eff.steer_enable_d, q.steer_eff.steer_enable_c,
                 q.steer_eff.steer_enable_b, q.steer_eff.steer_enable_a};
          act = own & {4{db_main}};
        end
      endcase
    end else if (half_bridge) begin
      own = 4'h3;
      act = {2'h0, db_comp, db_main};
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    case (WB_ADR_I)
      psdr_pkg::OFS_RESTART_DEADBAND: rbyte = q.rdb;
      psdr_pkg::OFS_PULSE_STEERING:   rbyte = {q.steer.compl_pair_select, 1'b0,
                                               q.steer[4:0]};
      psdr_pkg::OFS_MODE_CTRL:        rbyte = {1'b0, q.mode};
      psdr_pkg::OFS_SHUTDOWN_CTRL:    rbyte = q.sdc;
      psdr_pkg::OFS_PERIOD_LIMIT:     rbyte = q.period_limit;
      psdr_pkg::OFS_DUTY:             rbyte = q.duty;
      psdr_pkg::OFS_IRQ_STATUS:       rbyte = {6'h00, q.irq_stat};
      psdr_pkg::OFS_IRQ_MASK:         rbyte = {6'h00, q.irq_mask};
      default:                        rbyte = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.flt_s1 = FAULT_N;
    d.flt_s2 = q.flt_s1;
    d.cmp_s1 = {CMP2_OUT, CMP1_OUT};
    d.cmp_s2 = q.cmp_s1;
    d.ack    = req;
    if (req) begin
      d.rdata = {24'h000000, rbyte};
    end

    // Bus writes land on the edge that raises ack
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_RESTART_DEADBAND)) begin
      d.rdb = wbyte;
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_PULSE_STEERING)) begin
      d.steer = {wbyte[7:6], wbyte[4:0]};
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_MODE_CTRL)) begin
      d.mode = wbyte[6:0];
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_PERIOD_LIMIT)) begin
      d.period_limit = wbyte;
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_DUTY)) begin
      d.duty = wbyte;
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_IRQ_MASK)) begin
      d.irq_mask = wbyte[1:0];
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_IRQ_STATUS)) begin
      d.irq_stat = q.irq_stat & ~wbyte[1:0];
    end
    if (psdr_w1(WB_SEL_I[0], WB_WE_I && req,
                WB_ADR_I == psdr_pkg::OFS_SHUTDOWN_CTRL)) begin
      d.sdc.shutdown_source_sel    = wbyte[6:4];
      d.sdc.shutdown_state_pair_ac = wbyte[3:2];
      d.sdc.shutdown_state_pair_bd = wbyte[1:0];
      // Firmware may raise the flag; clearing is refused while the cause stands
      if (wbyte[7]) begin
        d.sdc.shutdown_event_flag = 1'b1;
      end else if (!sd_cond) begin
        d.sdc.shutdown_event_flag = 1'b0;
      end
    end

    // Core logic holds still in sleep so pins keep their levels
    if (!SLEEP) begin
      d.period_timer = period_start ? 8'h00
                     : (q.mode.timer_run ? q.period_timer + 8'h01 : q.period_timer);

      if (!q.steer.steer_sync_select) begin
        d.steer_eff = q.steer;
      end else if (period_start) begin
        d.steer_eff = q.steer;
      end

      if (sd_cond) begin
        d.sdc.shutdown_event_flag = 1'b1;
      end else if (q.rdb.restart_auto_enable && q.sdc.shutdown_event_flag) begin
        d.sdc.shutdown_event_flag = 1'b0;
      end

      if (q.sdc.shutdown_event_flag) begin
        d.shut_hold = 1'b1;
      end else if (period_start) begin
        d.shut_hold = 1'b0;
      end

      d.flag_prev = q.sdc.shutdown_event_flag;
      // Set wins over a clear written in the same cycle
      if (q.sdc.shutdown_event_flag && !q.flag_prev) begin
        d.irq_stat[psdr_pkg::IRQ_BIT_SHUTDOWN] = 1'b1;
      end
      if (period_start) begin
        d.irq_stat[psdr_pkg::IRQ_BIT_PERIOD] = 1'b1;
      end

      d.pin_own = own;
      d.pin_out = act ^ pol_low;
      d.pin_oe  = own;
      if (forced) begin
        // Only pins carrying PWM are forced; others stay with the port
        d.pin_out = own & {drv_bd[0], drv_ac[0], drv_bd[0], drv_ac[0]};
        d.pin_oe  = own & {drv_bd[1], drv_ac[1], drv_bd[1], drv_ac[1]};
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q              <= '0;
      q.rdb          <= psdr_pkg::RST_RESTART_DEADBAND;
      q.steer        <= psdr_pkg::RST_PULSE_STEERING;
      q.steer_eff    <= psdr_pkg::RST_PULSE_STEERING;
      q.mode         <= psdr_pkg::RST_MODE_CTRL;
      q.sdc          <= psdr_pkg::RST_SHUTDOWN_CTRL;
      q.period_limit <= psdr_pkg::RST_PERIOD_LIMIT;
      q.duty         <= psdr_pkg::RST_DUTY;
      q.flt_s1       <= 1'b1;
      q.flt_s2       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign WB_DAT_O     = q.rdata;
  assign WB_ACK_O     = q.ack;
  assign PWM_OUT      = q.pin_out;
  assign PWM_OE       = q.pin_oe;
  assign PWM_OWN      = q.pin_own;
  assign PERIOD_START = period_start;
  assign IRQ          = |(q.irq_stat & q.irq_mask);

endmodule : psdr_top
`default_nettype wire

// [dv/psdr_switch_drv.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Far-side switch drivers and fault sensors
// ****
module psdr_switch_drv (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic       trip_flt,
  input  wire logic       trip_c1,
  input  wire logic       trip_c2,
  output logic            fault_n,
  output logic            cmp1,
  output logic            cmp2,
  output logic      [3:0] pin_lvl
);
  // Pull-downs hold a released pin low so the switch stays off
  assign pin_lvl = pin_out & pin_oe;
  assign fault_n = ~trip_flt;
  assign cmp1    = trip_c1;
  assign cmp2    = trip_c2;
endmodule : psdr_switch_drv
`default_nettype wire

// [dv/psdr_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module psdr_properties (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SLEEP,
  input wire logic [3:0]  PWM_OUT,
  input wire logic [3:0]  PWM_OE,
  input wire logic [3:0]  PWM_OWN,
  input wire logic        PERIOD_START
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  logic rd_take;
  assign rd_take = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
  // ****
  // Register bus
  // ****
  AST_ACK_TAKE: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property ($rose(WB_ACK_O) |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_UNMAPPED_ZERO: assert property (rd_take && WB_ADR_I > 8'h1c |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  AST_STEER_BIT5: assert property (
    rd_take && WB_ADR_I == psdr_pkg::OFS_PULSE_STEERING |=> !WB_DAT_O[5])
    else $error("steering bit 5 reads one");
  // ****
  // Period strobe, sleep and pins
  // ****
  AST_PS_STROBE: assert property (PERIOD_START |=> !PERIOD_START)
    else $error("period start wider than one cycle");
  AST_SLEEP_FREEZE: assert property (
    SLEEP [*2] |-> $stable(PWM_OUT) && $stable(PWM_OE) && $stable(PWM_OWN))
    else $error("pins moved in sleep");
  AST_SLEEP_NO_PS: assert property (SLEEP |-> !PERIOD_START)
    else $error("period start in sleep");
  AST_OE_OWNED: assert property ((PWM_OE & ~PWM_OWN) == 4'h0)
    else $error("drive on pin not owned");
  cover property (SLEEP [*8]);
  cover property ($rose(PWM_OWN[3]));
  cover property (PERIOD_START ##1 !PERIOD_START);
endmodule : psdr_properties
bind psdr_top psdr_properties i_psdr_properties (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O),
  .SLEEP(SLEEP),
  .PWM_OUT(PWM_OUT),
  .PWM_OE(PWM_OE),
  .PWM_OWN(PWM_OWN),
  .PERIOD_START(PERIOD_START)
);
`default_nettype wire

// [dv/psdr_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module psdr_top_bench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        sleep = 1'b0;
  logic        trip_flt = 1'b0;
  logic        trip_c1 = 1'b0;
  logic        trip_c2 = 1'b0;
  logic [3:0]  sel = 4'h1;
  logic [31:0] rdat;
  logic        ack, ps, irq, fault_n, cmp1, cmp2;
  logic [3:0]  pout, poe, pown, plvl, snap;
  logic [7:0]  r;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // Ordinary accesses: write flag, address, data, expected read
  logic [24:0] rows [19] = '{
    25'h0_00_00_00, 25'h0_04_00_01, 25'h0_08_00_00, 25'h0_0c_00_00,
    25'h0_10_00_ff, 25'h0_14_00_80, 25'h0_1c_00_00, 25'h0_20_00_00,
    25'h1_04_ff_00, 25'h0_04_00_df, 25'h1_00_85_00, 25'h0_00_00_85,
    25'h1_20_55_00, 25'h0_20_00_00, 25'h1_00_00_00, 25'h1_10_0f_00,
    25'h1_14_04_00, 25'h1_04_0f_00, 25'h1_08_4c_00};

  always #2 ref_clk = ~ref_clk;

  psdr_top i_psdr_top (
    .REF_CLK(ref_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .SLEEP(sleep), .FAULT_N(fault_n),
    .CMP1_OUT(cmp1), .CMP2_OUT(cmp2), .PWM_OUT(pout), .PWM_OE(poe),
    .PWM_OWN(pown), .PERIOD_START(ps), .IRQ(irq));
  psdr_switch_drv i_psdr_switch_drv (
    .pin_out(pout), .pin_oe(poe), .trip_flt(trip_flt), .trip_c1(trip_c1),
    .trip_c2(trip_c2), .fault_n(fault_n), .cmp1(cmp1), .cmp2(cmp2), .pin_lvl(plvl));

  // ****
  // Shared tasks
  // ****
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : clk
  // Holds the request until ack is sampled, then leaves a one-cycle gap
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(r, exp);
  endtask : rd
  task waitps;
    do @(posedge ref_clk); while (ps !== 1'b1);
  endtask : waitps
  // High cycles of one pin over one 16-cycle period
  task cnt(input int i, input logic [7:0] exp);
    int n;
    n = 0;
    repeat (16) begin
      @(posedge ref_clk);
      if (plvl[i] === 1'b1) n++;
    end
    chk(8'(n), exp);
  endtask : cnt
  task end_of_test;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk(20000);
    error_cnt++;
    end_of_test();
  end

  // ****
  // Test sequence
  // ****
  initial begin
    clk(12);
    rst_n <= 1'b1;
    for (int i = 0; i < 19; i++) begin
      wb(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (!rows[i][24]) chk(r, rows[i][7:0]);
    end
    // A write without lane 0 enabled must leave the register alone
    sel <= 4'h0;
    wr(8'h14, 8'h33);
    sel <= 4'h1;
    rd(8'h14, 8'h04);
    clk(3);
    chk({4'h0, pown}, 8'h0f);
    wr(8'h08, 8'h40);
    clk(3);
    chk({4'h0, pown}, 8'h00);
    wr(8'h08, 8'h4c);
    cnt(0, 8'h04);
    wr(8'h08, 8'h4e);
    cnt(0, 8'h0c);
    cnt(1, 8'h04);
    wr(8'h08, 8'h4c);
    wr(8'h00, 8'h03);
    cnt(0, 8'h01);
    wr(8'h00, 8'h00);
    for (int p = 1; p < 4; p++) begin
      wr(8'h04, 8'(p << 6));
      clk(3);
      chk({4'h0, pown}, 8'(1 | (1 << p)));
      cnt(p, 8'h0c);
    end
    // Half bridge: dead band trims only the rising edge of A and of B
    wr(8'h00, 8'h02);
    wr(8'h08, 8'h6c);
    clk(3);
    chk({4'h0, pown}, 8'h03);
    cnt(0, 8'h02);
    cnt(1, 8'h0a);
    wr(8'h08, 8'h4c);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h01);
    clk(2);
    chk({4'h0, pown}, 8'h01);
    waitps();
    wr(8'h04, 8'h1f);
    clk(2);
    chk({4'h0, pown}, 8'h01);
    waitps();
    clk(2);
    chk({4'h0, pown}, 8'h0f);
    wr(8'h04, 8'h03);
    wr(8'h1c, 8'h01);
    wr(8'h0c, 8'h46);
    trip_flt <= 1'b1;
    clk(8);
    chk({4'h0, poe}, 8'h01);
    chk({7'h0, pout[0]}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd(8'h0c, 8'hc6);
    wr(8'h0c, 8'h46);
    rd(8'h0c, 8'hc6);
    trip_flt <= 1'b0;
    clk(8);
    rd(8'h0c, 8'hc6);
    waitps();
    wr(8'h0c, 8'h46);
    clk(2);
    chk({4'h0, poe}, 8'h01);
    waitps();
    clk(2);
    chk({4'h0, poe}, 8'h03);
    wr(8'h18, 8'h01);
    clk(2);
    chk({7'h0, irq}, 8'h00);
    rd(8'h18, 8'h02);
    wr(8'h00, 8'h80);
    wr(8'h0c, 8'h10);
    trip_c1 <= 1'b1;
    clk(8);
    chk({2'h0, poe[1:0], 2'h0, pout[1:0]}, 8'h30);
    trip_c1 <= 1'b0;
    clk(8);
    rd(8'h0c, 8'h10);
    wr(8'h0c, 8'h21);
    trip_c2 <= 1'b1;
    clk(8);
    chk({2'h0, poe[1:0], 2'h0, pout[1:0]}, 8'h32);
    trip_c2 <= 1'b0;
    clk(8);
    rd(8'h0c, 8'h21);
    waitps();
    clk(3);
    sleep <= 1'b1;
    clk(2);
    snap = pout;
    clk(20);
    chk({4'h0, pout}, {4'h0, snap});
    sleep <= 1'b0;
    rst_n <= 1'b0;
    clk(2);
    chk({4'h0, pown}, 8'h00);
    rst_n <= 1'b1;
    clk(1);
    rd(8'h04, 8'h01);
    end_of_test();
  end
endmodule : psdr_top_bench
`default_nettype wire
